// file: verilog/hcu_pkg.sv
package hcu_pkg;
   // bus geometry, register index is the word index, byte address is index times four
   localparam int         WB_ADR_W  = 4;
   localparam int         WB_DAT_W  = 32;
   localparam logic [1:0] FIFO_IDX  = 2'h0;
   localparam logic [1:0] STAT_IDX  = 2'h1;
   localparam logic [1:0] CMD_IDX   = 2'h2;
   localparam logic [1:0] CTRL_IDX  = 2'h3;
   localparam int         IDX_LSB   = 2;
   // transmit pool
   localparam int         FIFO_DEPTH = 32;
   localparam int         LVL_W      = 6;
   // command and control registers
   localparam int         CMD_W       = 8;
   localparam logic [7:0] CMD_RESET   = 8'h00;
   localparam logic [7:0] CMD_REP_TRN = 8'h24;
   localparam logic [1:0] CTRL_RESET  = 2'h0;
   // line coding
   localparam logic [7:0]  FLAG_PAT    = 8'h7E;
   localparam logic [3:0]  BYTE_LAST   = 4'h7;
   localparam logic [3:0]  CRC_LAST    = 4'hF;
   localparam logic [3:0]  ABORT_ONES  = 4'h7;
   localparam logic [2:0]  STUFF_AFTER = 3'h5;
   localparam logic [15:0] CRC_POLY    = 16'h8408;
   localparam logic [15:0] CRC_INIT    = 16'hFFFF;
   // command latency bound in half periods of the transmit bit rate
   localparam int          CMD_LAT_HALF = 5;
   localparam int          CLK_PERIOD_NS = 100;

   typedef struct packed {
      logic receive_block_done_cmd;
      logic receiver_reset_cmd;
      logic repeat_transmit_cmd;
      logic transmitter_reset_cmd;
      logic send_framed_cmd;
      logic send_transparent_cmd;
      logic message_end_cmd;
      logic signaling_tx_reset_cmd;
   } hcu_cmd_s;

   typedef struct packed {
      logic tx_clk_external;
      logic interframe_fill_select;
   } hcu_ctrl_s;

   typedef struct packed {
      logic [LVL_W-1:0] level;
      logic             repeat_active;
      logic             frame_active;
      logic             command_executing_flag;
   } hcu_stat_s;

   typedef enum logic [2:0] {
      ST_FILL  = 3'b000,
      ST_OPEN  = 3'b001,
      ST_DATA  = 3'b010,
      ST_CRC   = 3'b011,
      ST_CLOSE = 3'b100,
      ST_ABORT = 3'b101
   } hcu_tx_e;
endpackage

// file: verilog/hcu_top.sv
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
module hcu_top #(
   parameter int DEPTH = hcu_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                          clk_in,
   input  wire logic                          nrst_in,
   // wishbone slave
   input  wire logic                          wb_cyc_in,
   input  wire logic                          wb_stb_in,
   input  wire logic                          wb_we_in,
   input  wire logic [hcu_pkg::WB_ADR_W-1:0]  wb_adr_in,
   input  wire logic [3:0]                    wb_sel_in,
   input  wire logic [hcu_pkg::WB_DAT_W-1:0]  wb_dat_in,
   output logic      [hcu_pkg::WB_DAT_W-1:0]  wb_dat_out,
   output logic                               wb_ack_out,
   // transmit timing
   input  wire logic                          tx_bit_tick_in,
   input  wire logic                          tx_system_clock_in,
   // receive side handshake
   input  wire logic                          rx_fifo_empty_in,
   input  wire logic                          rx_block_start_in,
   // line and event outputs
   output logic                               tx_data_out,
   output logic                               tx_pool_ready_irq_out,
   output logic                               rx_block_done_out,
   output logic                               receiver_reset_out,
   output logic                               transmitter_reset_out,
   output logic                               rx_discard_next_out
);
   import hcu_pkg::*;

   localparam int PW = $clog2(DEPTH);

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
      crc_step = (c >> 1) ^ (((c[0] ^ b) == 1'b1) ? CRC_POLY : 16'h0000);
   endfunction

   logic [7:0]      mem [DEPTH];
   logic [PW-1:0]   wp_q, rp_q, rpos_q, rnext, rd_idx;
   logic [PW:0]     cnt_q, rlen_q, rcnt_q;
   logic            ack_q, acc, cmd_wr, fifo_wr, push, pop, flush, exec, tick;
   logic            sclk_q, busy_q, line_q, irq_q, rxd_q, receiver_reset_cmd_q, transmitter_reset_cmd_q, disc_q;
   logic            framed_q, endm_q, rep_q, stuff, fetch, start_t, start_h;
   logic [1:0]      nwr;
   logic [2:0]      ones_q;
   logic [3:0]      bit_q;
   logic [7:0]      sh_q, rd_byte;
   logic [15:0]     crc_q, crc_nx;
   logic [WB_DAT_W-1:0] rdat_q;
   hcu_cmd_s        pend_q;
   hcu_ctrl_s       ctrl_q;
   hcu_stat_s       stat;
   hcu_tx_e         st_q;

   // bus decode, one wait state on every access
   assign acc     = wb_cyc_in & wb_stb_in & ~ack_q;
   assign cmd_wr  = acc & wb_we_in & wb_sel_in[0] & (wb_adr_in[WB_ADR_W-1:IDX_LSB] == CMD_IDX);
   assign fifo_wr = acc & wb_we_in & (wb_adr_in[WB_ADR_W-1:IDX_LSB] == FIFO_IDX);

   assign stat.level                  = LVL_W'(cnt_q);
   assign stat.repeat_active          = rep_q;
   assign stat.frame_active           = (st_q != ST_FILL);
   assign stat.command_executing_flag = busy_q;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ack_q  <= 1'b0;
         rdat_q <= '0;
      end else begin
         ack_q  <= acc;
         rdat_q <= '0;
         if (acc && !wb_we_in) begin
            case (wb_adr_in[WB_ADR_W-1:IDX_LSB])
               STAT_IDX: rdat_q <= WB_DAT_W'(stat);
               CTRL_IDX: rdat_q <= WB_DAT_W'(ctrl_q);
               default:  rdat_q <= '0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ctrl_q <= hcu_ctrl_s'(CTRL_RESET);
      end else if (acc && wb_we_in && wb_sel_in[0] &&
                   wb_adr_in[WB_ADR_W-1:IDX_LSB] == CTRL_IDX) begin
         ctrl_q <= hcu_ctrl_s'(wb_dat_in[1:0]);
      end
   end

   // bit timing comes from the framer tick or from rising edges of the external clock
   assign tick = ctrl_q.tx_clk_external ? (tx_system_clock_in & ~sclk_q) : tx_bit_tick_in;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= tx_system_clock_in;
      end
   end

   // command holding: a write while busy is dropped, so a host must poll busy first;
   // with a dead external clock no tick comes and the register stays blocked
   assign exec = tick & busy_q;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         busy_q <= 1'b0;
         pend_q <= hcu_cmd_s'(CMD_RESET);
      end else if (cmd_wr && !busy_q) begin
         busy_q <= 1'b1;
         pend_q <= hcu_cmd_s'(wb_dat_in[CMD_W-1:0]);
      end else if (tick) begin
         busy_q <= 1'b0;
         pend_q <= hcu_cmd_s'(CMD_RESET);
      end
   end

   // receive and reset strobes toward the rest of the framer
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rxd_q  <= 1'b0;
         receiver_reset_cmd_q <= 1'b0;
         transmitter_reset_cmd_q <= 1'b0;
         disc_q <= 1'b0;
      end else begin
         rxd_q  <= exec & pend_q.receive_block_done_cmd;
         receiver_reset_cmd_q <= exec & pend_q.receiver_reset_cmd;
         transmitter_reset_cmd_q <= exec & pend_q.transmitter_reset_cmd;
         if (exec && pend_q.receive_block_done_cmd && rx_fifo_empty_in) begin
            disc_q <= 1'b1;
         end else if (rx_block_start_in) begin
            disc_q <= 1'b0;
         end
      end
   end

   // transmit pool
   assign nwr   = {1'b0, wb_sel_in[0]} + {1'b0, wb_sel_in[1]};
   assign push  = fifo_wr && (nwr != 2'h0) &&
                  ({1'b0, cnt_q} + (PW+2)'(nwr) <= (PW+2)'(DEPTH));
   assign flush = exec & (pend_q.signaling_tx_reset_cmd | (rep_q & ~pend_q.repeat_transmit_cmd));
   assign rnext = (rcnt_q == rlen_q - (PW+1)'(1)) ? rp_q : rpos_q + PW'(1);
   assign rd_idx  = rep_q ? rnext : rp_q;
   assign rd_byte = mem[rd_idx];

   always_ff @(posedge clk_in) begin
      if (push) begin
         if (wb_sel_in[0]) begin
            mem[wp_q] <= wb_dat_in[7:0];
         end
         if (wb_sel_in[1]) begin
            mem[wp_q + PW'(wb_sel_in[0])] <= wb_dat_in[15:8];
         end
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else if (flush) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         wp_q  <= wp_q + (push ? PW'(nwr) : PW'(0));
         rp_q  <= rp_q + PW'(pop);
         cnt_q <= cnt_q + (push ? (PW+1)'(nwr) : (PW+1)'(0)) - (PW+1)'(pop);
      end
   end

   // serialiser
   assign stuff   = framed_q & (ones_q == STUFF_AFTER) & (st_q == ST_DATA || st_q == ST_CRC);
   assign start_h = exec & (st_q == ST_FILL) & pend_q.send_framed_cmd & ~flush;
   assign start_t = exec & (st_q == ST_FILL) & pend_q.send_transparent_cmd &
                    ~pend_q.send_framed_cmd & ~flush & (cnt_q != '0);
   assign fetch   = tick & ~stuff & (bit_q == BYTE_LAST) & (st_q == ST_DATA || st_q == ST_OPEN);
   // repeated bytes are read in place and never leave the pool
   assign pop     = ((fetch & ~rep_q) | (start_t & ~pend_q.repeat_transmit_cmd)) &
                    ~flush & (cnt_q != '0);
   assign crc_nx  = crc_step(crc_q, sh_q[0]);

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_q     <= ST_FILL;
         line_q   <= 1'b1;
         irq_q    <= 1'b0;
         bit_q    <= '0;
         ones_q   <= '0;
         sh_q     <= '0;
         crc_q    <= CRC_INIT;
         framed_q <= 1'b0;
         endm_q   <= 1'b0;
         rep_q    <= 1'b0;
         rpos_q   <= '0;
         rlen_q   <= '0;
         rcnt_q   <= '0;
      end else begin
         irq_q <= 1'b0;
         if (tick) begin
            if (exec && pend_q.message_end_cmd) begin
               endm_q <= 1'b1;
            end
            case (st_q)
               ST_FILL: begin
                  line_q <= ctrl_q.interframe_fill_select ? FLAG_PAT[bit_q[2:0]] : 1'b1;
                  bit_q  <= {1'b0, bit_q[2:0] + 3'h1};
                  if (start_h) begin
                     st_q     <= ST_OPEN;
                     bit_q    <= '0;
                     framed_q <= 1'b1;
                     crc_q    <= CRC_INIT;
                     endm_q   <= pend_q.message_end_cmd;
                  end else if (start_t) begin
                     st_q     <= ST_DATA;
                     bit_q    <= '0;
                     framed_q <= 1'b0;
                     sh_q     <= rd_byte;
                     endm_q   <= pend_q.message_end_cmd;
                     rep_q    <= pend_q.repeat_transmit_cmd;
                     rpos_q   <= rp_q;
                     rlen_q   <= cnt_q;
                     rcnt_q   <= '0;
                  end
               end
               ST_OPEN: begin
                  line_q <= FLAG_PAT[bit_q[2:0]];
                  bit_q  <= bit_q + 4'h1;
                  if (bit_q == BYTE_LAST) begin
                     bit_q  <= '0;
                     ones_q <= '0;
                     sh_q   <= rd_byte;
                     st_q   <= (cnt_q != '0) ? ST_DATA : ST_ABORT;
                  end
               end
               ST_DATA: begin
                  if (stuff) begin
                     line_q <= 1'b0;
                     ones_q <= '0;
                  end else begin
                     line_q <= sh_q[0];
                     sh_q   <= sh_q >> 1;
                     ones_q <= sh_q[0] ? ones_q + 3'h1 : 3'h0;
                     bit_q  <= bit_q + 4'h1;
                     if (framed_q) begin
                        crc_q <= crc_nx;
                     end
                     if (bit_q == BYTE_LAST) begin
                        bit_q <= '0;
                        if (rep_q) begin
                           sh_q   <= rd_byte;
                           rpos_q <= rnext;
                           rcnt_q <= (rnext == rp_q) ? '0 : rcnt_q + (PW+1)'(1);
                        end else if (cnt_q != '0) begin
                           sh_q <= rd_byte;
                        end else if (framed_q && endm_q) begin
                           st_q <= ST_CRC;
                        end else if (!framed_q) begin
                           st_q   <= ST_FILL;
                           endm_q <= 1'b0;
                           irq_q  <= 1'b1;
                        end else begin
                           // pool ran dry mid frame: abort and ask for more data
                           st_q  <= ST_ABORT;
                           irq_q <= 1'b1;
                        end
                     end
                  end
               end
               ST_CRC: begin
                  if (stuff) begin
                     line_q <= 1'b0;
                     ones_q <= '0;
                  end else begin
                     line_q <= ~crc_q[0];
                     crc_q  <= crc_q >> 1;
                     ones_q <= ~crc_q[0] ? ones_q + 3'h1 : 3'h0;
                     bit_q  <= bit_q + 4'h1;
                     if (bit_q == CRC_LAST) begin
                        st_q  <= ST_CLOSE;
                        bit_q <= '0;
                     end
                  end
               end
               ST_CLOSE: begin
                  line_q <= FLAG_PAT[bit_q[2:0]];
                  bit_q  <= bit_q + 4'h1;
                  if (bit_q == BYTE_LAST) begin
                     st_q     <= ST_FILL;
                     bit_q    <= '0;
                     endm_q   <= 1'b0;
                     framed_q <= 1'b0;
                     irq_q    <= 1'b1;
                  end
               end
               ST_ABORT: begin
                  line_q <= 1'b1;
                  bit_q  <= bit_q + 4'h1;
                  if (bit_q == ABORT_ONES - 4'h1) begin
                     st_q     <= ST_FILL;
                     bit_q    <= '0;
                     framed_q <= 1'b0;
                     endm_q   <= 1'b0;
                  end
               end
               default: begin
                  st_q <= ST_FILL;
               end
            endcase
            if (exec && pend_q.signaling_tx_reset_cmd) begin
               st_q   <= ST_ABORT;
               bit_q  <= '0;
               rep_q  <= 1'b0;
               endm_q <= 1'b0;
               irq_q  <= 1'b1;
            end else if (flush) begin
               st_q   <= ST_FILL;
               bit_q  <= '0;
               rep_q  <= 1'b0;
               endm_q <= 1'b0;
            end
         end
      end
   end

   assign wb_dat_out            = rdat_q;
   assign wb_ack_out            = ack_q;
   assign tx_data_out           = line_q;
   assign tx_pool_ready_irq_out = irq_q;
   assign rx_block_done_out     = rxd_q;
   assign receiver_reset_out    = receiver_reset_cmd_q;
   assign transmitter_reset_out = transmitter_reset_cmd_q;
   assign rx_discard_next_out   = disc_q;

   // checks
   localparam int LAT_TICKS = CMD_LAT_HALF / 2;
   logic [1:0] lat_q;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         lat_q <= '0;
      end else begin
         lat_q <= !busy_q ? 2'h0 : (tick ? lat_q + 2'h1 : lat_q);
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   a_cmd_latency: assert property (lat_q <= 2'(LAT_TICKS))
      else $error("command held over too many bit periods");
   a_signaling_tx_reset_cmd_ready: assert property (exec && pend_q.signaling_tx_reset_cmd
      |=> tx_pool_ready_irq_out && st_q == ST_ABORT && cnt_q == '0)
      else $error("signaling reset did not flush and raise ready");
   a_abort_ones: assert property (st_q == ST_ABORT && tick && !exec |=> tx_data_out)
      else $error("abort sequence sent a zero");
   a_lsb_first: assert property (tick && st_q == ST_DATA && !stuff && !exec
      |=> tx_data_out == $past(sh_q[0]))
      else $error("data bit not least significant first");
   a_word_count: assert property (push && nwr == 2'h2 && !pop && !flush
      |=> cnt_q == $past(cnt_q) + (PW+1)'(2))
      else $error("word write did not add two bytes");
   a_word_order: assert property (push && wb_sel_in[1:0] == 2'h3
      |=> mem[$past(wp_q)] == $past(wb_dat_in[7:0]))
      else $error("low byte not first in pool");
   a_fill_ones: assert property (st_q == ST_FILL && tick && !ctrl_q.interframe_fill_select
      |=> tx_data_out)
      else $error("idle line not all ones");
   a_repeat_stop: assert property (exec && rep_q && !pend_q.repeat_transmit_cmd
      |=> !rep_q && st_q == ($past(pend_q.signaling_tx_reset_cmd) ? ST_ABORT : ST_FILL))
      else $error("repeat did not stop");
   a_repeat_keep: assert property (rep_q |-> !pop && !framed_q)
      else $error("repeat consumed pool or framed data");
   a_rx_discard: assert property (exec && pend_q.receive_block_done_cmd && rx_fifo_empty_in
      |=> rx_discard_next_out ##0 rx_block_done_out)
      else $error("discard not armed on empty receive pool");
   a_receiver_reset_cmd_pulse: assert property (receiver_reset_out |=> !receiver_reset_out)
      else $error("receiver reset strobe too long");
   a_close_after: assert property ($rose(st_q == ST_CLOSE) |-> $past(st_q) == ST_CRC)
      else $error("closing flag without check sequence");
endmodule

// file: test/hcu_host.sv
`timescale 1ns/100ps
module hcu_host (
   // clock
   input  wire logic        clk_in,
   // bus answer
   input  wire logic        ack_in,
   input  wire logic [31:0] dat_in,
   // bus request, strobe follows cycle
   output logic             cyc_out,
   output logic             we_out,
   output logic [3:0]       adr_out,
   output logic [3:0]       sel_out,
   output logic [31:0]      dat_out
);
   import hcu_pkg::*;
   logic quiet_q = 1'b0;

   initial begin
      {cyc_out, we_out, adr_out, sel_out, dat_out} = '0;
   end

   // request held until ack is seen at an edge, released only then
   task automatic xfer(input logic w, input logic [3:0] a, input logic [3:0] s,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_in);
      {cyc_out, we_out, adr_out, sel_out, dat_out} <= {1'b1, w, a, s, d};
      @(posedge clk_in);
      while (ack_in !== 1'b1) @(posedge clk_in);
      q = dat_in;
      cyc_out <= 1'b0;
      we_out <= 1'b0;
   endtask

   // polls are not compared, the bench only checks its own reads
   task automatic cmd(input hcu_cmd_s c);
      logic [31:0] st;
      quiet_q <= 1'b1;
      st = 32'h1;
      while (st[0] === 1'b1) xfer(1'b0, {STAT_IDX, 2'h0}, 4'hF, '0, st);
      quiet_q <= 1'b0;
      xfer(1'b1, {CMD_IDX, 2'h0}, 4'h1, {24'h0, c}, st);
   endtask
endmodule

// file: test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import hcu_pkg::*;
   logic        clk_in = 1'b0;
   logic        nrst_in = 1'b0;
   logic        tick = 1'b0;
   logic        tick_d = 1'b0;
   logic        sclk = 1'b0;
   logic        rx_empty = 1'b0;
   logic        rx_start = 1'b0;
   logic        cyc, we, ack, txd, disc;
   logic [3:0]  adr, sel;
   wire  [3:0]  pv;
   logic [31:0] wd, rdat, v;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   logic [7:0]  ct[4] = '{8'h01, 8'h80, 8'h40, 8'h10};
   int          mismatches = 0;
   int          n_tests = 0;
   int          cycles = 0;
   int          seed = 71403;
   int          n;
   int          irqs = 0;
   int          i0;

   always #(CLK_PERIOD_NS / 2) clk_in = ~clk_in;

   hcu_host host_inst (.clk_in(clk_in), .ack_in(ack), .dat_in(rdat), .cyc_out(cyc),
      .we_out(we), .adr_out(adr), .sel_out(sel), .dat_out(wd));
   hcu_top #(.DEPTH(FIFO_DEPTH)) hcu_top_inst (.clk_in(clk_in), .nrst_in(nrst_in),
      .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
      .wb_dat_in(wd), .wb_dat_out(rdat), .wb_ack_out(ack), .tx_bit_tick_in(tick),
      .tx_system_clock_in(sclk), .rx_fifo_empty_in(rx_empty), .rx_block_start_in(rx_start),
      .tx_data_out(txd), .tx_pool_ready_irq_out(pv[0]), .rx_block_done_out(pv[1]),
      .receiver_reset_out(pv[2]), .transmitter_reset_out(pv[3]), .rx_discard_next_out(disc));

   // bit period of eight clocks keeps frames short
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      tick <= (cycles % 8 == 7);
      tick_d <= tick;
      // ready pulses are counted, since some fall inside a capture window
      if (pv[0] === 1'b1) irqs <= irqs + 1;
      if (cycles == 30000) begin
         mismatches = mismatches + 1;
         conclude();
      end
   end

   always @(posedge clk_in) begin
      if (ack === 1'b1 && we === 1'b0 && host_inst.quiet_q === 1'b0) begin
         cmp_rd(rdat, exp_q.pop_front(), msk_q.pop_front());
      end
   end

   task automatic cmp_rd(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
      n_tests++;
      if ((got & m) !== (e & m)) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got & m, e & m);
      end
   endtask

   task automatic cmp_ev(input logic [31:0] got, input logic [31:0] e);
      cmp_rd(got, e, '1);
   endtask

   task automatic wr(input logic [1:0] i, input logic [3:0] s, input logic [31:0] d);
      logic [31:0] q;
      host_inst.xfer(1'b1, {i, 2'h0}, s, d, q);
   endtask

   task automatic rd(input logic [1:0] i, input logic [31:0] e, input logic [31:0] m);
      logic [31:0] q;
      exp_q.push_back(e);
      msk_q.push_back(m);
      host_inst.xfer(1'b0, {i, 2'h0}, 4'hF, '0, q);
   endtask

   task automatic wp(input int b, input int lim, output int c);
      c = 0;
      do begin
         @(posedge clk_in);
         c++;
      end while (pv[b] !== 1'b1 && c < lim);
   endtask

   // sync waits for the first zero, since the idle line is all ones
   task automatic grab(input bit sy, input int nb, output logic [31:0] q);
      int g;
      q = '0;
      g = 0;
      while (sy && g < 600 && !(tick_d === 1'b1 && txd === 1'b0)) begin
         @(posedge clk_in);
         g++;
      end
      for (int i = 0; i < nb; i++) begin
         if (i > 0 || !sy) do @(posedge clk_in); while (tick_d !== 1'b1);
         q[i] = txd;
      end
   endtask

   task automatic fin(input string s);
      $display("test %s done", s);
   endtask

   task automatic conclude();
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge clk_in);
      nrst_in <= 1'b1;
      @(posedge clk_in);
      cmp_ev(txd, 1);
      rd(STAT_IDX, 0, 32'h1FF);
      rd(CMD_IDX, 0, '1);
      rd(CTRL_IDX, 0, '1);
      fin("reset");
      wr(FIFO_IDX, 4'h1, $random(seed));
      for (int i = 0; i < 16; i++) wr(FIFO_IDX, 4'h3, $random(seed));
      repeat (2) wr(FIFO_IDX, 4'h1, $random(seed));
      rd(STAT_IDX, 32 << 3, 32'h1F8);
      host_inst.cmd(8'h01);
      wp(0, 40, n);
      cmp_ev(n <= 21, 1);
      rd(STAT_IDX, 0, 32'h1F8);
      fin("pool");
      wr(CTRL_IDX, 4'h1, 32'h1);
      for (int k = 1; k < 4; k++) begin
         host_inst.cmd(ct[k]);
         wp(k, 40, n);
         cmp_ev(n <= 21, 1);
         wp(k, 40, n);
         cmp_ev(n, 40);
      end
      rd(CTRL_IDX, 1, 32'h3);
      grab(0, 24, v);
      n = 0;
      for (int i = 0; i < 8; i++) if (v[i +: 16] === 16'h7E7E) n = 1;
      cmp_ev(n, 1);
      wr(CTRL_IDX, 4'h1, 32'h0);
      repeat (100) @(posedge clk_in);
      grab(0, 16, v);
      cmp_ev(v[15:0], 16'hFFFF);
      fin("commands");
      wr(FIFO_IDX, 4'h3, 32'h3412);
      host_inst.cmd(8'h0A);
      grab(1, 24, v);
      cmp_ev(v[23:0], 24'h34127E);
      wp(0, 600, n);
      cmp_ev(n < 600, 1);
      rd(STAT_IDX, 0, 32'h1FE);
      fin("frame");
      for (int s = 0; s < 3; s++) begin
         wr(FIFO_IDX, 4'h1, 32'h80);
         i0 = irqs;
         host_inst.cmd(s == 0 ? 8'h04 : 8'h24);
         grab(1, 24, v);
         cmp_ev(v[23:0], s == 0 ? 24'hFFFF80 : 24'h808080);
         if (s > 0) host_inst.cmd(s == 1 ? 8'h00 : 8'h01);
         if (s == 2) wp(0, 600, n);
         // the stop command needs a bit period before status reflects it
         repeat (20) @(posedge clk_in);
         cmp_ev(irqs - i0, s != 1);
         rd(STAT_IDX, 0, 32'h1FC);
      end
      fin("transparent");
      rx_empty <= 1'b1;
      host_inst.cmd(8'h80);
      wp(1, 40, n);
      @(posedge clk_in);
      cmp_ev(disc, 1);
      rx_start <= 1'b1;
      @(posedge clk_in);
      rx_start <= 1'b0;
      rx_empty <= 1'b0;
      repeat (2) @(posedge clk_in);
      cmp_ev(disc, 0);
      fin("discard");
      // without external edges the second command must be lost
      wr(CTRL_IDX, 4'h1, 32'h2);
      wr(CMD_IDX, 4'h1, 32'h10);
      wr(CMD_IDX, 4'h1, 32'h40);
      rd(STAT_IDX, 1, 32'h1);
      sclk <= 1'b1;
      wp(3, 40, n);
      cmp_ev(n < 40, 1);
      wp(2, 40, n);
      cmp_ev(n, 40);
      wr(CTRL_IDX, 4'h1, 32'h0);
      fin("external clock");
      conclude();
   end
endmodule
